// *** hw/cex_pkg.sv ***
/*
  package for the exception control block: vector offsets, cause codes,
  machine state bit positions, register offsets and carrier types.
  assumes a 32-bit core with one core clock.
*/
package cex_pkg;

  localparam int          CEX_AW        = 32;
  localparam logic [31:0] CEX_BASE_LOW  = 32'h0000_0000;
  localparam logic [31:0] CEX_BASE_HIGH = 32'hFFF0_0000;

  // vector offsets
  localparam logic [31:0] CEX_VO_RESET  = 32'h0000_0100;
  localparam logic [31:0] CEX_VO_MCHK   = 32'h0000_0200;
  localparam logic [31:0] CEX_VO_DACC   = 32'h0000_0300;
  localparam logic [31:0] CEX_VO_IACC   = 32'h0000_0400;
  localparam logic [31:0] CEX_VO_EXT    = 32'h0000_0500;
  localparam logic [31:0] CEX_VO_ALIGN  = 32'h0000_0600;
  localparam logic [31:0] CEX_VO_PROG   = 32'h0000_0700;
  localparam logic [31:0] CEX_VO_FPUN   = 32'h0000_0800;
  localparam logic [31:0] CEX_VO_DEC    = 32'h0000_0900;
  localparam logic [31:0] CEX_VO_SC     = 32'h0000_0C00;
  localparam logic [31:0] CEX_VO_TRACE  = 32'h0000_0D00;
  localparam logic [31:0] CEX_VO_FPAS   = 32'h0000_0E00;
  localparam logic [31:0] CEX_VO_SWEM   = 32'h0000_1000;
  localparam logic [31:0] CEX_VO_NMI    = 32'h0000_1F00;

  // machine state register bit positions (our layout)
  localparam int CEX_MS_RECOV  = 0;
  localparam int CEX_MS_PREFIX = 1;
  localparam int CEX_MS_EXTEN  = 2;
  localparam int CEX_MS_SUPER  = 3;
  localparam logic [31:0] CEX_MS_RST = 32'h0000_000A;

  // register offsets on the plain port
  localparam logic [3:0] CEX_R_MSR    = 4'h0;
  localparam logic [3:0] CEX_R_RET    = 4'h1;
  localparam logic [3:0] CEX_R_SAVED  = 4'h2;
  localparam logic [3:0] CEX_R_DAR    = 4'h3;
  localparam logic [3:0] CEX_R_DATA_FAULT_CAUSE_REG  = 4'h4;
  localparam logic [3:0] CEX_R_FPS    = 4'h5;
  localparam logic [3:0] CEX_R_CAUSE  = 4'h6;
  localparam logic [3:0] CEX_R_IST    = 4'h7;
  localparam logic [3:0] CEX_R_IEN    = 4'h8;
  localparam logic [3:0] CEX_R_ICLR   = 4'h9;
  localparam logic [3:0] CEX_R_SWEN   = 4'hA;
  localparam logic [3:0] CEX_R_RFI    = 4'hB;

  localparam int CEX_NSYNC = 10;
  localparam logic [4:0] CEX_SWEN_RST = 5'h1F;

  typedef enum logic [3:0] {
    CC_NONE  = 4'h0, CC_RESET = 4'h1, CC_MCHK = 4'h2, CC_DACC = 4'h3,
    CC_IACC  = 4'h4, CC_EXT   = 4'h5, CC_ALIGN = 4'h6, CC_PROG = 4'h7,
    CC_FPUN  = 4'h8, CC_DEC   = 4'h9, CC_SC    = 4'hA, CC_TRACE = 4'hB,
    CC_FPAS  = 4'hC, CC_SWEM  = 4'hD, CC_NMI   = 4'hE
  } cex_cause_type;

  // one retiring instruction with its fault report
  typedef struct packed {
    logic                       valid;
    logic [31:0]                pc;
    logic [CEX_NSYNC-1:0]       fault;
    logic                       after;  // resume at next instruction
    logic [31:0]                daddr;
    logic [31:0]                dcause;
    logic [31:0]                fstat;
  } cex_retire_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } cex_redirect_type;

endpackage : cex_pkg

// *** hw/cex_prio.sv ***
/*
  fixed-priority picker: lowest set bit of the request vector wins.
  assumes requests are steady for the cycle they are sampled in.
*/
`timescale 1ns/100ps
`default_nettype none
module cex_prio
  import cex_pkg::*;
#(
  parameter int N = CEX_NSYNC
) (
  input  wire logic [N-1:0] req_i,
  output logic      [N-1:0] grant_o,
  output logic              any_o
);
  initial begin
    if (N < 1 || N > 32) $error("cex_prio width out of range");
  end
  assign grant_o = req_i & (~req_i + N'(1));
  assign any_o   = |req_i;
endmodule : cex_prio
`default_nettype wire

// *** hw/cex_vec.sv ***
/*
  vector address former: base from the prefix bit plus per-cause offset.
  assumes an encoded cex_cause_type cause code from the controller.
*/
`timescale 1ns/100ps
`default_nettype none
module cex_vec
  import cex_pkg::*;
(
  input  wire logic          prefix_i,
  input  wire cex_cause_type cause_i,
  output logic [31:0]        vec_o
);
  logic [31:0] offs;
  always_comb begin
    case (cause_i)
      CC_RESET: offs = CEX_VO_RESET;
      CC_MCHK:  offs = CEX_VO_MCHK;
      CC_DACC:  offs = CEX_VO_DACC;
      CC_IACC:  offs = CEX_VO_IACC;
      CC_EXT:   offs = CEX_VO_EXT;
      CC_ALIGN: offs = CEX_VO_ALIGN;
      CC_PROG:  offs = CEX_VO_PROG;
      CC_FPUN:  offs = CEX_VO_FPUN;
      CC_DEC:   offs = CEX_VO_DEC;
      CC_SC:    offs = CEX_VO_SC;
      CC_TRACE: offs = CEX_VO_TRACE;
      CC_FPAS:  offs = CEX_VO_FPAS;
      CC_SWEM:  offs = CEX_VO_SWEM;
      CC_NMI:   offs = CEX_VO_NMI;
      default:  offs = CEX_VO_RESET;
    endcase
  end
  assign vec_o = (prefix_i ? CEX_BASE_HIGH : CEX_BASE_LOW) | offs;
endmodule : cex_vec
`default_nettype wire

// *** hw/cex_ctrl.sv ***
/*
  exception control: classifies sources, saves state, redirects fetch,
  keeps the recoverable flag and a small register port.
  assumes the pipeline presents the oldest unretired instruction on retire_i
  and cancels younger work when flush_o pulses.
*/
// Functional notes
// - save state, supervisor, fetch from vector
// - shared vectors, cause kept in status registers
// - software enables suppress selected exceptions
// - reset, nmi, machine check unordered
// - ordered exceptions reported one at a time
// - resume execution after handler returns
// - ordered entry loses no program state
// - unordered exceptions accepted at any moment; code ignores them in ST_RESET and does not capture their cause in ST_SAVE
// - reset never returns to interrupted program
// - nested nmi or check may corrupt saves
// - copy recoverable flag then clear it
// - recoverable flag readable in saved state
// - vector base by prefix bit plus offset
// - precise: return points at faulting or next
// - take only at retirement, cancel younger
`timescale 1ns/100ps
`default_nettype none
module cex_ctrl
  import cex_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire cex_retire_type   retire_i,
  input  wire logic             ext_irq_i,
  input  wire logic             dec_irq_i,
  input  wire logic             mchk_i,
  input  wire logic             nmi_i,
  input  wire logic [31:0]      cur_pc_i,
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  output cex_redirect_type      redirect_o,
  output logic                  flush_o,
  output logic                  retire_ok_o,
  output logic                  supervisor_o,
  output logic                  irq_o
);

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01,
    ST_SAVE  = 2'b10,
    ST_GO    = 2'b11
  } cex_state_type;

  cex_state_type state_q, state_d;
  logic [31:0] msr_q, ret_q, saved_q, dar_q, data_fault_cause_reg_q, fps_q;
  logic [31:0] pend_ret_q, vec_q;
  cex_cause_type cause_q, pend_cause_q;
  logic [3:0]  ist_q, ien_q;
  logic [4:0]  swen_q;
  logic [31:0] rdata_q;
  cex_redirect_type redir_q;
  logic        flush_q;

  // sync fault filtering by software enables
  logic [CEX_NSYNC-1:0] sync_req, sync_gnt;
  logic                 sync_any;
  assign sync_req = retire_i.valid ? (retire_i.fault & {5'h1F, swen_q}) :
                    {CEX_NSYNC{1'b0}};
  cex_prio #(.N(CEX_NSYNC)) u_prio (
    .req_i   (sync_req),
    .grant_o (sync_gnt),
    .any_o   (sync_any)
  );

  function automatic cex_cause_type sync_cause(input logic [CEX_NSYNC-1:0] g);
    cex_cause_type c;
    c = CC_PROG;
    case (1'b1)
      g[0]: c = CC_IACC;
      g[1]: c = CC_DACC;
      g[2]: c = CC_ALIGN;
      g[3]: c = CC_PROG;
      g[4]: c = CC_FPUN;
      g[5]: c = CC_FPAS;
      g[6]: c = CC_SWEM;
      g[7]: c = CC_SC;
      g[8]: c = CC_TRACE;
      default: c = CC_PROG;
    endcase
    return c;
  endfunction : sync_cause

  // classification
  wire logic run        = (state_q == ST_RUN);
  wire logic unord      = nmi_i | mchk_i;
  wire logic ext_take   = ext_irq_i & msr_q[CEX_MS_EXTEN];
  wire logic dec_take   = dec_irq_i & msr_q[CEX_MS_EXTEN];
  wire logic ord_async  = (ext_take | dec_take) & retire_i.valid;
  wire logic take_unord = unord & (state_q != ST_RESET);
  wire logic take_ord   = run & ~take_unord & (sync_any | ord_async);
  wire logic take       = take_unord | take_ord;

  wire cex_cause_type new_cause =
      nmi_i     ? CC_NMI :
      mchk_i    ? CC_MCHK :
      sync_any  ? sync_cause(sync_gnt) :
      ext_take  ? CC_EXT : CC_DEC;

  // precise resume point: faulting instruction or the next one
  wire logic [31:0] new_ret =
      take_unord ? cur_pc_i :
      (sync_any & retire_i.after) ? retire_i.pc + 32'h0000_0004 :
      retire_i.pc;

  wire logic [31:0] vec_addr;
  cex_vec u_vec (
    .prefix_i (msr_q[CEX_MS_PREFIX]),
    .cause_i  (state_q == ST_RESET ? CC_RESET : pend_cause_q),
    .vec_o    (vec_addr)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = ST_GO;
      ST_RUN:   state_d = take ? ST_SAVE : ST_RUN;
      ST_SAVE:  state_d = ST_GO;
      ST_GO:    state_d = take_unord ? ST_SAVE : ST_RUN;
      default:  state_d = ST_RESET;
    endcase
    if (take_unord && state_q == ST_SAVE) state_d = ST_SAVE;
  end

  // register port decode
  wire logic wr_msr  = reg_wr_i & (reg_addr_i == CEX_R_MSR);
  wire logic wr_ret  = reg_wr_i & (reg_addr_i == CEX_R_RET);
  wire logic wr_sav  = reg_wr_i & (reg_addr_i == CEX_R_SAVED);
  wire logic wr_ien  = reg_wr_i & (reg_addr_i == CEX_R_IEN);
  wire logic wr_iclr = reg_wr_i & (reg_addr_i == CEX_R_ICLR);
  wire logic wr_swen = reg_wr_i & (reg_addr_i == CEX_R_SWEN);
  wire logic wr_rfi  = reg_wr_i & (reg_addr_i == CEX_R_RFI) & run & ~take;

  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      CEX_R_MSR:   rd_mux = msr_q;
      CEX_R_RET:   rd_mux = ret_q;
      CEX_R_SAVED: rd_mux = saved_q;
      CEX_R_DAR:   rd_mux = dar_q;
      CEX_R_DATA_FAULT_CAUSE_REG: rd_mux = data_fault_cause_reg_q;
      CEX_R_FPS:   rd_mux = fps_q;
      CEX_R_CAUSE: rd_mux = {28'h0, cause_q};
      CEX_R_IST:   rd_mux = {28'h0, ist_q};
      CEX_R_IEN:   rd_mux = {28'h0, ien_q};
      CEX_R_SWEN:  rd_mux = {27'h0, swen_q};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // interrupt events: entry by ordered, unordered, nested unordered, return
  wire logic nested = take_unord & ~msr_q[CEX_MS_RECOV];
  wire logic [3:0] ev = {wr_rfi, nested, take_unord, take_ord};

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // pending save captured at take; registers written in ST_SAVE
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_ret_q   <= 32'h0000_0000;
      pend_cause_q <= CC_NONE;
    end else if (take && state_q != ST_SAVE) begin
      pend_ret_q   <= new_ret;
      pend_cause_q <= new_cause;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      msr_q   <= CEX_MS_RST;
      ret_q   <= 32'h0000_0000;
      saved_q <= 32'h0000_0000;
      cause_q <= CC_RESET;
    end else if (state_q == ST_SAVE) begin
      ret_q   <= pend_ret_q;
      saved_q <= msr_q;
      msr_q   <= (msr_q | (32'h1 << CEX_MS_SUPER))
                 & ~(32'h1 << CEX_MS_RECOV) & ~(32'h1 << CEX_MS_EXTEN);
      cause_q <= pend_cause_q;
    end else if (wr_rfi) begin
      msr_q   <= saved_q;
    end else begin
      if (wr_msr) msr_q   <= reg_wdata_i;
      if (wr_ret) ret_q   <= reg_wdata_i;
      if (wr_sav) saved_q <= reg_wdata_i;
    end
  end

  // cause detail registers for shared vectors
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dar_q   <= 32'h0000_0000;
      data_fault_cause_reg_q <= 32'h0000_0000;
      fps_q   <= 32'h0000_0000;
    end else if (take_ord & sync_any & state_q == ST_RUN) begin
      dar_q   <= retire_i.daddr;
      data_fault_cause_reg_q <= retire_i.dcause;
      fps_q   <= retire_i.fstat;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ist_q  <= 4'h0;
      ien_q  <= 4'h0;
      swen_q <= CEX_SWEN_RST;
    end else begin
      ist_q <= (ist_q & ~(wr_iclr ? reg_wdata_i[3:0] : 4'h0)) | ev;        // set wins over clear
      if (wr_ien)  ien_q  <= reg_wdata_i[3:0];
      if (wr_swen) swen_q <= reg_wdata_i[4:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
      redir_q <= '0;
      flush_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
      redir_q.valid <= (state_q == ST_GO) | wr_rfi;
      redir_q.addr  <= wr_rfi ? ret_q : vec_addr;
      flush_q <= take;
    end
  end

  // younger work is cancelled by flush; retire blocked on the taken cycle
  assign retire_ok_o  = run & ~take & retire_i.valid;
  assign reg_rdata_o  = rdata_q;
  assign redirect_o   = redir_q;
  assign flush_o      = flush_q;
  assign supervisor_o = msr_q[CEX_MS_SUPER];
  assign irq_o        = |(ist_q & ien_q);

  // checks
  a_save_after_take: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (take && state_q == ST_RUN) |=> state_q == ST_SAVE) else $error("take not saved");
  a_recov_copied: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_q == ST_SAVE |=> saved_q[CEX_MS_RECOV] == $past(msr_q[CEX_MS_RECOV])
    && !msr_q[CEX_MS_RECOV]) else $error("recover flag not moved");
  a_super_entry: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_q == ST_SAVE |=> supervisor_o) else $error("not supervisor");
  a_redirect_late: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state_q == ST_SAVE && state_d == ST_GO) |=> ##1 redirect_o.valid) else $error("no redirect");
  a_one_ordered: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take_ord |-> $onehot(sync_gnt) || !sync_any) else $error("several reported");
  a_no_retire_take: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take |-> !retire_ok_o) else $error("retired on take");
  a_flush_follows: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take |=> flush_o) else $error("no flush");
  a_enable_gates: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (run && !msr_q[CEX_MS_EXTEN] && !sync_any && !unord) |-> !take) else $error("masked taken");
  a_reset_vector: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $rose(state_q == ST_GO) && $past(state_q) == ST_RESET |=> redirect_o.addr[15:0] == 16'h0100)
    else $error("reset vector");
  a_unord_any: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (unord && state_q != ST_RESET) |=> state_q == ST_SAVE) else $error("unordered ignored");
  c_sync_take: cover property (@(posedge core_clk_i) take_ord && sync_any);
  c_ext_take: cover property (@(posedge core_clk_i) take_ord && ext_take && !sync_any);
  c_nested: cover property (@(posedge core_clk_i) nested);
  c_return: cover property (@(posedge core_clk_i) wr_rfi);

endmodule : cex_ctrl
`default_nettype wire

// *** dv/cex_pipe_model.sv ***
/*
  pipeline stand-in: presents one retiring instruction, drops it on flush,
  re-presents it when fetch comes back to its pc.
  assumes cex_ctrl drives redirect two clocks after flush.
*/
`timescale 1ns/100ps
`default_nettype none
module cex_pipe_model
  import cex_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ld_i,
  input  wire logic [31:0]      ld_pc_i,
  input  wire logic [9:0]       ld_fault_i,
  input  wire logic             ld_after_i,
  input  wire logic             retire_ok_i,
  input  wire logic             flush_i,
  input  wire cex_redirect_type redirect_i,
  output cex_retire_type        retire_o,
  output logic      [31:0]      cur_pc_o,
  output logic                  busy_o
);
  logic        pend_q;
  logic [31:0] pc_q;
  logic [9:0]  fault_q;
  logic        after_q;
  // idle pc and fault show the inverse, so a stray sample never matches
  assign retire_o = '{valid: pend_q, pc: pend_q ? pc_q : ~pc_q, fault: pend_q ? fault_q : ~fault_q,
                      after: after_q, daddr: pc_q ^ 32'h5A5A_0000, dcause: {22'h0, fault_q}, fstat: pc_q + 32'h1};
  assign cur_pc_o = pc_q;
  assign busy_o   = pend_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q  <= 1'b0;
      pc_q    <= '0;
      fault_q <= '0;
      after_q <= 1'b0;
    end else if (ld_i) begin
      pend_q  <= 1'b1;
      pc_q    <= ld_pc_i;
      fault_q <= ld_fault_i;
      after_q <= ld_after_i;
    end else if (flush_i) begin
      pend_q  <= 1'b0;
      fault_q <= fault_q & (fault_q - 10'h1);
    end else if (redirect_i.valid && redirect_i.addr == pc_q && !pend_q) begin
      pend_q <= 1'b1;
    end else if (pend_q && retire_ok_i) begin
      pend_q <= 1'b0;
    end
  end
endmodule : cex_pipe_model
`default_nettype wire

// *** dv/cex_ctrl_bench.sv ***
/*
  self-checking bench for cex_ctrl with the pipeline stand-in.
  assumes the package constants and the register map of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module cex_ctrl_bench;
  import cex_pkg::*;
  logic             core_clk_i, nrst_i, ext_irq, dec_irq, mchk, nmi, reg_wr, reg_rd;
  logic             ld, ld_after, busy, flush, retire_ok, supervisor, irq, aft;
  logic [3:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, cur_pc, ld_pc, d, a, pc;
  logic [9:0]       ld_fault;
  cex_retire_type   retire;
  cex_redirect_type redirect;
  integer           seed;
  int               err_total = 0, cmp_count = 0, cyc = 0, redir_cnt = 0, n0;
  localparam logic [31:0] voff_tab [10] = '{CEX_VO_IACC, CEX_VO_DACC, CEX_VO_ALIGN, CEX_VO_PROG, CEX_VO_FPUN,
                                            CEX_VO_FPAS, CEX_VO_SWEM, CEX_VO_SC, CEX_VO_TRACE, CEX_VO_PROG};
  localparam cex_cause_type code_tab [10] = '{CC_IACC, CC_DACC, CC_ALIGN, CC_PROG, CC_FPUN, CC_FPAS, CC_SWEM,
                                              CC_SC, CC_TRACE, CC_PROG};
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  cex_ctrl dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .retire_i(retire), .ext_irq_i(ext_irq),
    .dec_irq_i(dec_irq), .mchk_i(mchk), .nmi_i(nmi), .cur_pc_i(cur_pc), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .redirect_o(redirect), .flush_o(flush), .retire_ok_o(retire_ok), .supervisor_o(supervisor), .irq_o(irq));
  cex_pipe_model pipe (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ld_i(ld), .ld_pc_i(ld_pc),
    .ld_fault_i(ld_fault), .ld_after_i(ld_after), .retire_ok_i(retire_ok), .flush_i(flush),
    .redirect_i(redirect), .retire_o(retire), .cur_pc_o(cur_pc), .busy_o(busy));
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr  <= ad;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rc(input logic [3:0] ad, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rc
  task automatic wait_redir();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (redirect.valid !== 1'b1 && n < 60);
    a = redirect.addr;
  endtask : wait_redir
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 60);
  endtask : wait_idle
  task automatic load(input logic [31:0] p, input logic [9:0] f, input logic af);
    @(posedge core_clk_i);
    ld       <= 1'b1;
    ld_pc    <= p;
    ld_fault <= f;
    ld_after <= af;
    @(posedge core_clk_i);
    ld <= 1'b0;
    #1;
  endtask : load
  // one ordered entry and its return; expects the handler left flag set
  task automatic one_exc(input int k, input logic [31:0] p, input logic af);
    wait_redir();
    chk(a, CEX_BASE_HIGH | voff_tab[k]);
    chk(supervisor, 1'b1);
    rc(CEX_R_RET, af ? p + 32'h4 : p);
    rc(CEX_R_SAVED, 32'h0000_000B);
    rc(CEX_R_MSR, 32'h0000_000A);
    rc(CEX_R_CAUSE, {28'h0, code_tab[k]});
    if (k == 1) rc(CEX_R_DAR, p ^ 32'h5A5A_0000);
    wr(CEX_R_RFI, 32'h0);
    chk(redirect.valid, 1'b1);
    chk(redirect.addr, af ? p + 32'h4 : p);
  endtask : one_exc
  always @(posedge core_clk_i) begin
    cyc++;
    if (redirect.valid === 1'b1) redir_cnt++;
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    seed = 32'ha87a;
    {nrst_i, ext_irq, dec_irq, mchk, nmi, reg_wr, reg_rd, ld, ld_after} = '0;
    {reg_addr, reg_wdata, ld_pc, ld_fault} = '0;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    wait_redir();
    chk(a, CEX_BASE_HIGH | CEX_VO_RESET);
    rc(CEX_R_MSR, CEX_MS_RST);
    rc(4'hC, 32'h0);
    rc(CEX_R_SWEN, {27'h0, CEX_SWEN_RST});
    wr(CEX_R_IEN, 32'hF);
    for (int k = 0; k < 10; k++) begin
      d = $random(seed);
      pc = d & 32'hFFFF_FFFC;
      aft = d[31];
      wr(CEX_R_MSR, 32'hB);
      load(pc, 10'h1 << k, aft);
      one_exc(k, pc, aft);
      wait_idle();
    end
    // two conditions on one instruction, seen one after the other
    wr(CEX_R_MSR, 32'hB);
    load(pc, 10'h00A, 1'b0);
    one_exc(1, pc, 1'b0);
    one_exc(3, pc, 1'b0);
    wait_idle();
    wr(CEX_R_SWEN, 32'h1B);
    n0 = redir_cnt;
    load(pc, 10'h004, 1'b0);
    wait_idle();
    chk(redir_cnt, n0);
    wr(CEX_R_SWEN, 32'h1F);
    for (int j = 0; j < 2; j++) begin
      wr(CEX_R_MSR, 32'h8);
      @(posedge core_clk_i);
      ext_irq <= (j == 0);
      dec_irq <= (j == 1);
      n0 = redir_cnt;
      load(pc + 32'h10, 10'h0, 1'b0);
      wait_idle();
      chk(redir_cnt, n0);
      wr(CEX_R_MSR, 32'hC);
      load(pc, 10'h0, 1'b0);
      wait_redir();
      chk(a, CEX_BASE_LOW | (j ? CEX_VO_DEC : CEX_VO_EXT));
      ext_irq <= 1'b0;
      dec_irq <= 1'b0;
      rc(CEX_R_RET, pc);
      wr(CEX_R_RFI, 32'h0);
      wait_idle();
    end
    rc(CEX_R_IST, 32'h9);
    wr(CEX_R_ICLR, 32'hF);
    rc(CEX_R_IST, 32'h0);
    for (int j = 0; j < 2; j++) begin
      wr(CEX_R_MSR, j ? 32'hB : 32'hA);
      @(posedge core_clk_i);
      nmi  <= (j == 0);
      mchk <= (j == 1);
      @(posedge core_clk_i);
      nmi  <= 1'b0;
      mchk <= 1'b0;
      wait_redir();
      chk(a, CEX_BASE_HIGH | (j ? CEX_VO_MCHK : CEX_VO_NMI));
      rc(CEX_R_CAUSE, j ? CC_MCHK : CC_NMI);
      rc(CEX_R_RET, pc);
      rc(CEX_R_SAVED, j ? 32'hB : 32'hA);
      rc(CEX_R_IST, j ? 32'h2 : 32'h6);
      chk(irq, 1'b1);
      wr(CEX_R_IEN, 32'h1);
      @(posedge core_clk_i);
      #1;
      chk(irq, 1'b0);
      wr(CEX_R_ICLR, 32'hF);
      wr(CEX_R_IEN, 32'hF);
      rc(CEX_R_IST, 32'h0);
    end
    wr(CEX_R_CAUSE, 32'h5);
    rc(CEX_R_CAUSE, CC_MCHK);
    complete_run();
  end
endmodule : cex_ctrl_bench
`default_nettype wire
